// ==== common/cpb_params.svh ====
`ifndef CPB_PARAMS_SVH
`define CPB_PARAMS_SVH
// Active-low cycle status codes on the three status lines.
`define CPB_CS_INTA 3'h0
`define CPB_CS_IORD 3'h1
`define CPB_CS_IOWR 3'h2
`define CPB_CS_HALT 3'h3
`define CPB_CS_FETCH 3'h4
`define CPB_CS_MRD 3'h5
`define CPB_CS_MWR 3'h6
`define CPB_CS_PASSIVE 3'h7
// Segment register codes shown on the two segment status lines.
`define CPB_SEG_ALT 2'h0
`define CPB_SEG_STACK 2'h1
`define CPB_SEG_CODE 2'h2
`define CPB_SEG_DATA 2'h3
// Fixed status bit values.
`define CPB_FIXED_ZERO 1'h0
`define CPB_UPPER_STATUS 1'h0
// Vector type raised by the non-maskable input.
`define CPB_NMI_TYPE 8'h02
// Least reset width in clock cycles.
`define CPB_RESET_MIN_CYC 4
// Default wait states inserted by the far end.
`define CPB_WAIT_STATES 0
// Words of memory modelled by the far end.
`define CPB_MEM_WORDS 256
// Level read on a floated bus (pull-ups).
`define CPB_AD_FLOAT 16'hFFFF
`endif

// ==== common/cpb_pkg.sv ====
package cpb_pkg;
`include "cpb_params.svh"

  typedef enum logic [2:0] {
    CPB_INTA = `CPB_CS_INTA,
    CPB_IORD = `CPB_CS_IORD,
    CPB_IOWR = `CPB_CS_IOWR,
    CPB_HALT = `CPB_CS_HALT,
    CPB_FETCH = `CPB_CS_FETCH,
    CPB_MRD = `CPB_CS_MRD,
    CPB_MWR = `CPB_CS_MWR,
    CPB_PASSIVE = `CPB_CS_PASSIVE
  } cpb_cyc_e;

  typedef enum logic [6:0] {
    CPB_IDLE = 7'h01,
    CPB_T1 = 7'h02,
    CPB_T2 = 7'h04,
    CPB_T3 = 7'h08,
    CPB_WAIT_STATE = 7'h10,
    CPB_T4 = 7'h20,
    CPB_HOLD = 7'h40
  } cpb_state_e;

  typedef struct packed {
    cpb_state_e state;
    logic pend;
    cpb_cyc_e kind;
    logic [19:0] addr;
    logic [1:0] ben;
    logic [15:0] wdata;
    logic [1:0] seg;
    logic rst_meta;
    logic run;
    logic irq_m;
    logic irq_s;
    logic test_m;
    logic test_s;
    logic nmi_m;
    logic nmi_s;
    logic nmi_d;
    logic nmi_pend;
    logic mode_m;
    logic mode_s;
    logic [15:0] ad_out;
    logic ad_oe;
    logic [3:0] as_out;
    logic bhe_n;
    logic read_n;
    logic pins_oe;
    logic cs_oe;
    cpb_cyc_e cs;
    logic resp_valid;
    logic [15:0] rdata;
    logic irq_take;
    logic nmi_take;
    logic wait_release;
    logic hold_ack;
  } cpb_dev_s;

  typedef struct packed {
    logic [7:0] rst_cnt;
    logic cpu_reset;
    logic irq;
    logic nmi;
    logic test_n;
    cpb_cyc_e cs_prev;
    logic pend;
    logic busy;
    cpb_cyc_e kind;
    logic [19:0] addr;
    logic bhe_n;
    logic a0;
    logic [7:0] cnt;
    logic ready;
    logic ad_oe;
    logic [15:0] ad_out;
    logic ev_valid;
    cpb_cyc_e ev_kind;
    logic [19:0] ev_addr;
    logic [15:0] ev_data;
  } cpb_host_s;
endpackage

// ==== common/cpb_if.sv ====
`timescale 1ns/10ps
`include "cpb_params.svh"
// Pin-level link between the processor end and the bus controller end.
interface cpb_if;
  // Multiplexed address/data lines, one driver set per end.
  logic [15:0] ad_dev_out;
  logic ad_dev_oe;
  logic [15:0] ad_host_out;
  logic ad_host_oe;
  // Address/status lines: [3] fixed_zero_status, [2] int_enable_status,
  // [1] segment_status_hi, [0] segment_status_lo.
  logic [3:0] addr_status_out;
  logic addr_status_oe;
  logic upper_byte_enable_n_out;
  logic upper_byte_enable_n_oe;
  logic read_n_out;
  logic read_n_oe;
  logic [2:0] cycle_status_out;
  logic cycle_status_oe;
  // Inputs of the processor end, driven by the far end.
  logic ready;
  logic maskable_irq;
  logic test_n;
  logic nonmask_irq;
  logic cpu_reset;
  logic mode_select;
  // Resolved wire levels; floated lines read high through pull-ups.
  logic [15:0] addr_data_bus;
  logic [3:0] addr_status;
  logic upper_byte_enable_n;
  logic read_n;
  logic [2:0] cycle_status;

  assign addr_data_bus = ad_dev_oe ? ad_dev_out :
                         (ad_host_oe ? ad_host_out : `CPB_AD_FLOAT);
  assign addr_status = addr_status_oe ? addr_status_out : 4'hF;
  assign upper_byte_enable_n = upper_byte_enable_n_oe ? upper_byte_enable_n_out : 1'b1;
  assign read_n = read_n_oe ? read_n_out : 1'b1;
  assign cycle_status = cycle_status_oe ? cycle_status_out : `CPB_CS_PASSIVE;

  modport dev (
    output ad_dev_out, ad_dev_oe, addr_status_out, addr_status_oe,
    output upper_byte_enable_n_out, upper_byte_enable_n_oe,
    output read_n_out, read_n_oe, cycle_status_out, cycle_status_oe,
    input addr_data_bus, ready, maskable_irq, test_n, nonmask_irq,
    input cpu_reset, mode_select
  );

  modport host (
    output ad_host_out, ad_host_oe, ready, maskable_irq, test_n,
    output nonmask_irq, cpu_reset, mode_select,
    input addr_data_bus, addr_status, upper_byte_enable_n, read_n,
    input cycle_status
  );
endinterface // cpb_if

// ==== verilog/cpb_dev.sv ====
`timescale 1ns/10ps
// Contract
// - Address in T1, data in T2 to T4.
// - Low address bit low for lower-byte moves.
// - Float address/data in acknowledge and hold.
// - Top address in T1, zero for I/O.
// - Status T2 to T4, enable bit refreshed per clock.
// - Segment code on two bits, sixth bit zero.
// - Float address/status lines in hold.
// - Upper enable low for upper byte, then status.
// - Upper enable and low bit encode transfer size.
// - Upper enable low in first acknowledge, floats in hold.
// - Read strobe low T2 to waits, floats hold.
// - Far end drives ready, meeting setup unsynchronised.
// - Sample maskable request at instruction end, if enabled.
// - Wait instruction continues on synchronised test low.
// - Rising non-maskable edge raises unmaskable type two.
// - Reset held four clocks, aborts, restarts after.
// - Far end supplies the one processor clock.
// - Mode input selects minimum or maximum pin use.
// - Cycle status active T4-T2, passive T3 or ready.
// - Status change starts cycle, passive ends it.
// - Float cycle status lines in hold.
// - Codes for acknowledge, I/O read, write, halt.
`include "cpb_params.svh"
module cpb_dev (
  // Clock and reset.
  input logic ref_clk,
  input logic rst,
  // Pin side.
  cpb_if.dev link,
  // Bus cycle requests from the execution unit.
  input logic req_valid,
  output logic req_ready,
  input cpb_pkg::cpb_cyc_e req_kind,
  input logic [19:0] req_addr,
  input logic [1:0] req_ben,
  input logic [15:0] req_wdata,
  input logic [1:0] req_seg,
  // Completion of each bus cycle.
  output logic resp_valid,
  output logic [15:0] resp_rdata,
  // Instruction-level control.
  input logic int_enable,
  input logic instr_last,
  input logic wait_instr,
  output logic wait_release,
  output logic irq_take,
  output logic nmi_take,
  output logic [7:0] nmi_type,
  output logic max_mode,
  // Local bus hold.
  input logic hold_req,
  output logic hold_ack
);
  import cpb_pkg::*;

  cpb_dev_s s;
  cpb_dev_s n;
  logic reset_any;
  logic accept;
  logic ready_now;

  // Either the system reset or the reset pin aborts at once, without the clock.
  assign reset_any = rst | link.cpu_reset;

  // Ready goes straight into the state logic; the far end owns its setup time.
  assign ready_now = link.ready & ((s.state == CPB_T3) | (s.state == CPB_WAIT_STATE));

  // A new cycle is taken from idle, or at the close of a transfer so that its
  // status can already be shown during the coming T4.
  assign req_ready = s.run & ~hold_req & ((s.state == CPB_IDLE) | ready_now);
  assign accept = req_valid & req_ready;

  // Pin drivers.
  assign link.ad_dev_out = s.ad_out;
  assign link.ad_dev_oe = s.ad_oe & s.pins_oe;
  assign link.addr_status_out = s.as_out;
  assign link.addr_status_oe = s.pins_oe;
  assign link.upper_byte_enable_n_out = s.bhe_n;
  assign link.upper_byte_enable_n_oe = s.pins_oe;
  assign link.read_n_out = s.read_n;
  assign link.read_n_oe = s.pins_oe;
  // Status drops to passive as soon as ready is seen in T3 or a wait state.
  assign link.cycle_status_out = ready_now ? `CPB_CS_PASSIVE : s.cs;
  assign link.cycle_status_oe = s.cs_oe;

  // User side outputs.
  assign resp_valid = s.resp_valid;
  assign resp_rdata = s.rdata;
  assign wait_release = s.wait_release;
  assign irq_take = s.irq_take;
  assign nmi_take = s.nmi_take;
  assign nmi_type = `CPB_NMI_TYPE;
  assign max_mode = s.mode_s;
  assign hold_ack = s.hold_ack;

  function automatic logic is_read(input cpb_cyc_e k);
    is_read = (k == CPB_FETCH) | (k == CPB_MRD) | (k == CPB_IORD);
  endfunction

  function automatic logic is_write(input cpb_cyc_e k);
    is_write = (k == CPB_MWR) | (k == CPB_IOWR);
  endfunction

  function automatic logic is_mem(input cpb_cyc_e k);
    is_mem = (k == CPB_FETCH) | (k == CPB_MRD) | (k == CPB_MWR);
  endfunction

  // Next-state logic for the whole end.
  always_comb begin
    n = s;
    // Reset release is re-timed so restart begins on a clean edge.
    n.rst_meta = 1'b1;
    n.run = s.rst_meta;
    // Two-flop synchronisers for every asynchronous pin.
    n.irq_m = link.maskable_irq;
    n.irq_s = s.irq_m;
    n.test_m = link.test_n;
    n.test_s = s.test_m;
    n.nmi_m = link.nonmask_irq;
    n.nmi_s = s.nmi_m;
    n.nmi_d = s.nmi_s;
    n.mode_m = link.mode_select;
    n.mode_s = s.mode_m;
    n.resp_valid = 1'b0;
    n.irq_take = 1'b0;
    n.nmi_take = 1'b0;
    n.wait_release = wait_instr & ~s.test_s;
    // The non-maskable event wins over the maskable one and ignores the enable.
    if (instr_last && s.nmi_pend) begin
      n.nmi_take = 1'b1;
      n.nmi_pend = 1'b0;
    end else if (instr_last && s.irq_s && int_enable) begin
      n.irq_take = 1'b1;
    end
    // A fresh edge sets the pending flag even in the cycle it is consumed.
    if (s.nmi_s && !s.nmi_d) begin
      n.nmi_pend = 1'b1;
    end
    if (accept) begin
      n.pend = 1'b1;
      n.kind = req_kind;
      n.addr = req_addr;
      n.ben = req_ben;
      n.wdata = req_wdata;
      n.seg = req_seg;
    end
    case (s.state)
      CPB_IDLE: begin
        if (hold_req) begin
          n.state = CPB_HOLD;
        end else if (accept) begin
          n.state = CPB_T4;
          n.cs = req_kind;
        end
      end
      CPB_T1: begin
        n.state = CPB_T2;
        // Data phase: drive write data, float for reads and acknowledge.
        n.ad_oe = is_write(s.kind);
        n.ad_out = s.wdata;
        n.read_n = ~is_read(s.kind);
      end
      CPB_T2: begin
        n.state = CPB_T3;
      end
      CPB_T3, CPB_WAIT_STATE: begin
        if (link.ready) begin
          n.state = CPB_T4;
          n.resp_valid = 1'b1;
          n.rdata = link.addr_data_bus;
          n.read_n = 1'b1;
          n.cs = accept ? req_kind : CPB_PASSIVE;
        end else begin
          n.state = CPB_WAIT_STATE;
        end
      end
      CPB_T4: begin
        n.ad_oe = 1'b0;
        if (s.pend) begin
          n.state = CPB_T1;
          n.pend = 1'b0;
          // Address phase.
          n.ad_out = {s.addr[15:1], ~s.ben[0]};
          n.ad_oe = (s.kind != CPB_INTA);
          n.as_out = is_mem(s.kind) ? s.addr[19:16] : 4'h0;
          n.bhe_n = ~s.ben[1];
        end else if (hold_req) begin
          n.state = CPB_HOLD;
        end else begin
          n.state = CPB_IDLE;
        end
      end
      CPB_HOLD: begin
        if (!hold_req) begin
          n.state = CPB_IDLE;
        end
      end
      default: begin
        n.state = CPB_IDLE;
      end
    endcase
    // Outside T1 the shared lines carry status, refreshed every clock.
    if (n.state != CPB_T1) begin
      n.as_out = {`CPB_FIXED_ZERO, int_enable, n.seg};
      n.bhe_n = `CPB_UPPER_STATUS;
    end
    // Everything floats in hold; cycle status is driven in maximum mode only.
    n.pins_oe = s.run & (n.state != CPB_HOLD);
    n.cs_oe = n.pins_oe & s.mode_s;
    n.hold_ack = (n.state == CPB_HOLD);
  end

  // State register; reset takes constants only and floats every pin.
  always_ff @(posedge ref_clk or posedge reset_any) begin
    if (reset_any) begin
      s <= '0;
      s.state <= CPB_IDLE;
      s.kind <= CPB_PASSIVE;
      s.bhe_n <= 1'b1;
      s.read_n <= 1'b1;
      s.cs <= CPB_PASSIVE;
    end else begin
      s <= n;
    end
  end
endmodule // cpb_dev

// ==== verilog/cpb_host.sv ====
`timescale 1ns/10ps
`include "cpb_params.svh"
module cpb_host #(
  parameter int WAIT_STATES = `CPB_WAIT_STATES,
  parameter int MEM_WORDS = `CPB_MEM_WORDS,
  parameter int RESET_CYCLES = `CPB_RESET_MIN_CYC,
  parameter bit MAX_MODE = 1'b1
) (
  // Clock and reset.
  input logic ref_clk,
  input logic rst,
  // Pin side.
  cpb_if.host link,
  // Levels to place on the processor inputs.
  input logic irq_req,
  input logic nmi_req,
  input logic test_level_n,
  input logic [7:0] irq_vector,
  input logic [15:0] io_rd_data,
  // One report per finished bus cycle.
  output logic ev_valid,
  output cpb_pkg::cpb_cyc_e ev_kind,
  output logic [19:0] ev_addr,
  output logic [15:0] ev_data
);
  import cpb_pkg::*;

  localparam int AW = $clog2(MEM_WORDS);

  cpb_host_s s;
  cpb_host_s n;
  logic [15:0] mem [MEM_WORDS];
  logic [AW-1:0] idx;
  logic start;
  logic done;
  logic rd_kind;
  logic [15:0] rd_word;

  assign link.ad_host_out = s.ad_out;
  assign link.ad_host_oe = s.ad_oe;
  assign link.ready = s.ready;
  assign link.maskable_irq = s.irq;
  assign link.nonmask_irq = s.nmi;
  assign link.test_n = s.test_n;
  assign link.cpu_reset = s.cpu_reset;
  assign link.mode_select = MAX_MODE;
  assign ev_valid = s.ev_valid;
  assign ev_kind = s.ev_kind;
  assign ev_addr = s.ev_addr;
  assign ev_data = s.ev_data;

  // Cycle boundaries as the bus controller sees them on the status lines.
  assign start = !s.busy && !s.pend && (s.cs_prev == CPB_PASSIVE) &&
                 (link.cycle_status != `CPB_CS_PASSIVE);
  assign done = s.busy && s.ready && (link.cycle_status == `CPB_CS_PASSIVE);
  assign idx = s.addr[AW:1];
  assign rd_kind = (s.kind == CPB_INTA) | (s.kind == CPB_IORD) |
                   (s.kind == CPB_FETCH) | (s.kind == CPB_MRD);
  assign rd_word = (s.kind == CPB_INTA) ? {8'h00, irq_vector} :
                   ((s.kind == CPB_IORD) ? io_rd_data : mem[idx]);

  // Next-state logic of the controller and responder.
  always_comb begin
    n = s;
    n.irq = irq_req;
    n.nmi = nmi_req;
    n.test_n = test_level_n;
    n.ev_valid = 1'b0;
    // The reset pin is held for the full count after the system reset.
    if (s.rst_cnt != 8'(RESET_CYCLES)) begin
      n.rst_cnt = s.rst_cnt + 8'h01;
    end
    n.cpu_reset = (n.rst_cnt != 8'(RESET_CYCLES));
    n.cs_prev = cpb_cyc_e'(link.cycle_status);
    if (start) begin
      n.pend = 1'b1;
      n.kind = cpb_cyc_e'(link.cycle_status);
    end
    // The cycle after the status change is T1: latch the address.
    if (s.pend) begin
      n.pend = 1'b0;
      n.busy = 1'b1;
      n.addr = {link.addr_status, link.addr_data_bus};
      n.bhe_n = link.upper_byte_enable_n;
      n.a0 = link.addr_data_bus[0];
      n.cnt = 8'h00;
      n.ready = 1'b0;
    end
    if (s.busy) begin
      n.cnt = (s.cnt == 8'hFF) ? s.cnt : s.cnt + 8'h01;
      n.ready = (32'(s.cnt) >= WAIT_STATES);
      n.ad_oe = rd_kind;
      n.ad_out = rd_word;
    end
    if (done) begin
      n.busy = 1'b0;
      n.ready = 1'b0;
      n.ad_oe = 1'b0;
      n.ev_valid = 1'b1;
      n.ev_kind = s.kind;
      n.ev_addr = s.addr;
      n.ev_data = rd_kind ? s.ad_out : link.addr_data_bus;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.cpu_reset <= 1'b1;
      s.test_n <= 1'b1;
      s.cs_prev <= CPB_PASSIVE;
      s.kind <= CPB_PASSIVE;
      s.ev_kind <= CPB_PASSIVE;
    end else begin
      s <= n;
    end
  end

  // Memory has no reset; byte lanes follow the upper enable and low bit.
  always_ff @(posedge ref_clk) begin
    if (done && s.kind == CPB_MWR) begin
      if (!s.bhe_n) begin
        mem[idx][15:8] <= link.addr_data_bus[15:8];
      end
      if (!s.a0) begin
        mem[idx][7:0] <= link.addr_data_bus[7:0];
      end
    end
  end
endmodule // cpb_host

// ==== verification/cpb_monitor.sv ====
`timescale 1ns/10ps
// Watches the pins between the processor end and the bus controller end.
module cpb_monitor (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Link signals.
  input wire logic ad_dev_oe,
  input wire logic addr_status_oe,
  input wire logic upper_byte_enable_n_oe,
  input wire logic read_n_oe,
  input wire logic cycle_status_oe,
  input wire logic ready,
  input wire logic cpu_reset,
  input wire logic [3:0] addr_status,
  input wire logic read_n,
  input wire logic [2:0] cycle_status
);
  logic act;
  logic [7:0] cnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst || cpu_reset);
  // A cycle is active while the status lines show anything but passive.
  assign act = cycle_status != 3'h7;
  // Counts active cycles: T4 reads 0, T1 1, T2 2, T3 and waits 3 or more.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= 8'h00;
    end else begin
      cnt <= (act && cnt != 8'hFF) ? cnt + 8'h01 : 8'h00;
    end
  end
  AST_ACTIVE_SPAN: assert property (
    $rose(act) |-> act [*3]) else $error("Status did not stay active over T4 to T2.");
  AST_PASSIVE_ON_READY: assert property (
    (cnt >= 8'h03 && ready) |-> !act) else $error("Status active in T3 or wait with ready.");
  AST_IO_TOP_LOW: assert property (
    $rose(act) && (cycle_status == 3'h1 || cycle_status == 3'h2) |=> addr_status == 4'h0)
    else $error("Top address lines not low in I/O T1.");
  AST_READ_STROBE: assert property (
    $rose(act) && (cycle_status == 3'h1 || cycle_status == 3'h5) |=> read_n ##1 !read_n [*2])
    else $error("Read strobe not high in T1 and low in T2 and T3.");
  AST_WRITE_NO_STROBE: assert property (
    act && (cycle_status == 3'h2 || cycle_status == 3'h6) |-> read_n)
    else $error("Read strobe low during a write.");
  AST_INTA_FLOAT: assert property (
    act && cycle_status == 3'h0 |-> !ad_dev_oe) else $error("Bus driven in acknowledge.");
  AST_WRITE_DRIVE: assert property (
    $rose(act) && (cycle_status == 3'h2 || cycle_status == 3'h6) |=> ad_dev_oe [*3])
    else $error("Bus not driven in T1 to T3 of a write.");
  AST_READ_RELEASE: assert property (
    $rose(act) && cycle_status inside {3'h1, 3'h4, 3'h5} |=> ad_dev_oe ##1 !ad_dev_oe)
    else $error("Bus not released in T2 of a read.");
  AST_FIXED_ZERO: assert property (
    act && cnt == 8'h02 && cycle_status != 3'h0 && cycle_status != 3'h3 |-> !addr_status[3])
    else $error("Sixth status bit not zero.");
  AST_FLOAT_TOGETHER: assert property (
    addr_status_oe == read_n_oe && upper_byte_enable_n_oe == read_n_oe)
    else $error("Address status, enable and strobe lines float apart.");
  AST_RESET_FLOAT: assert property (@(posedge ref_clk) disable iff (rst)
    cpu_reset |-> !ad_dev_oe && !addr_status_oe && !cycle_status_oe)
    else $error("Pins driven while held in reset.");
endmodule // cpb_monitor

// ==== verification/cpb_tb_top.sv ====
`timescale 1ns/10ps
// Joins both ends and walks every cycle type and every control input but the mode select across the pins.
module cpb_tb_top;
  import cpb_pkg::*;
  localparam int WS = 1;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic req_valid = 1'h0;
  cpb_cyc_e req_kind = CPB_PASSIVE;
  logic [19:0] req_addr = 20'h00000;
  logic [1:0] req_ben = 2'h3;
  logic [15:0] req_wdata = 16'h0000;
  logic [1:0] req_seg = 2'h0;
  logic int_enable = 1'h0;
  logic instr_last = 1'h0;
  logic wait_instr = 1'h0;
  logic hold_req = 1'h0;
  logic irq_req = 1'h0;
  logic nmi_req = 1'h0;
  logic test_level_n = 1'h1;
  logic req_ready, resp_valid, wait_release, irq_take, nmi_take, max_mode, hold_ack, ev_valid;
  logic [15:0] resp_rdata, ev_data, ed, t1_bus;
  logic [7:0] nmi_type;
  logic [19:0] ev_addr, ea;
  logic [3:0] t1_as, t2_as;
  logic [2:0] ek, cs_q = 3'h7;
  logic [1:0] ph = 2'h0;
  logic t1_bhe;
  cpb_cyc_e ev_kind;
  int n_errors = 0, n_tests = 0, n_ev = 0, n_resp = 0, n_irq = 0, n_nmi = 0, cyc = 0;
  cpb_cyc_e kd [8] = '{CPB_MWR, CPB_MWR, CPB_MRD, CPB_FETCH, CPB_IORD, CPB_IOWR, CPB_INTA,
                       CPB_HALT};
  logic [19:0] ad [8] = '{20'h30012, 20'h30013, 20'h30012, 20'h30012, 20'h50044, 20'h00046,
                          20'h00000, 20'h00000};
  logic [1:0] bn [8] = '{2'h3, 2'h2, 2'h3, 2'h1, 2'h3, 2'h3, 2'h3, 2'h3};
  logic [15:0] mk [8] = '{16'hFFFF, 16'hFF00, 16'hFFFF, 16'h00FF, 16'hFFFF, 16'hFFFF, 16'h00FF,
                          16'h0000};
  logic [15:0] ex [8] = '{16'h5566, 16'hAB00, 16'hAB66, 16'h0066, 16'hC3A5, 16'h7E81, 16'h004D,
                          16'h0000};

  cpb_if link ();
  cpb_dev cpb_dev_inst (.ref_clk(ref_clk), .rst(rst), .link(link), .req_valid(req_valid),
    .req_ready(req_ready), .req_kind(req_kind), .req_addr(req_addr), .req_ben(req_ben),
    .req_wdata(req_wdata), .req_seg(req_seg), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .int_enable(int_enable), .instr_last(instr_last),
    .wait_instr(wait_instr), .wait_release(wait_release), .irq_take(irq_take),
    .nmi_take(nmi_take), .nmi_type(nmi_type), .max_mode(max_mode), .hold_req(hold_req),
    .hold_ack(hold_ack));
  cpb_host #(.WAIT_STATES(WS)) cpb_host_inst (.ref_clk(ref_clk), .rst(rst), .link(link),
    .irq_req(irq_req), .nmi_req(nmi_req), .test_level_n(test_level_n),
    .irq_vector(8'h4D), .io_rd_data(16'hC3A5), .ev_valid(ev_valid), .ev_kind(ev_kind),
    .ev_addr(ev_addr), .ev_data(ev_data));
  cpb_monitor cpb_monitor_inst (.ref_clk(ref_clk), .rst(rst), .ad_dev_oe(link.ad_dev_oe),
    .addr_status_oe(link.addr_status_oe), .upper_byte_enable_n_oe(link.upper_byte_enable_n_oe),
    .read_n_oe(link.read_n_oe), .cycle_status_oe(link.cycle_status_oe), .ready(link.ready),
    .cpu_reset(link.cpu_reset), .addr_status(link.addr_status), .read_n(link.read_n),
    .cycle_status(link.cycle_status));

  // Free-running 25 ns clock, high for a third of each period as the processor expects.
  always #(ref_clk ? 8.33 : 16.67) ref_clk = ~ref_clk;

  // Samples at the falling edge, where everything has settled; also cuts a hang short.
  always @(negedge ref_clk) begin
    if (ph == 2'h1) begin
      t1_as = link.addr_status;
      t1_bus = link.addr_data_bus;
      t1_bhe = link.upper_byte_enable_n;
    end
    if (ph == 2'h2) t2_as = link.addr_status;
    ph = (ph == 2'h0) ? 2'h0 : ph + 2'h1;
    if (cs_q == 3'h7 && link.cycle_status != 3'h7) ph = 2'h1;
    cs_q = link.cycle_status;
    if (ev_valid) begin
      n_ev++;
      ek = ev_kind;
      ed = ev_data;
      ea = ev_addr;
    end
    if (resp_valid) n_resp++;
    if (irq_take) n_irq++;
    if (nmi_take) n_nmi++;
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Holds the request until taken, then waits for both ends to report the cycle.
  task automatic bus_op(input int i, input logic [1:0] sg);
    int e;
    int r;
    e = n_ev;
    r = n_resp;
    @(posedge ref_clk);
    req_valid <= 1'h1;
    req_kind <= kd[i];
    req_addr <= ad[i];
    req_ben <= bn[i];
    req_wdata <= ex[i];
    req_seg <= sg;
    do @(negedge ref_clk); while (req_ready !== 1'h1);
    @(posedge ref_clk);
    req_valid <= 1'h0;
    while (n_ev == e || n_resp == r) @(negedge ref_clk);
  endtask

  // Ends one instruction after the synchronisers have had time to settle.
  task automatic last_instr();
    repeat (6) @(posedge ref_clk);
    instr_last <= 1'h1;
    @(posedge ref_clk);
    instr_last <= 1'h0;
    settle(4);
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence; every drive lands on a rising edge or 1 ns after one.
  initial begin
    logic wr;
    logic io;
    settle(12);
    rst <= 1'h0;
    settle(3);
    check({link.cpu_reset, req_ready}, 20'h2);
    while (req_ready !== 1'h1) settle(1);
    check(max_mode, 1'h1);
    for (int j = 0; j < 2; j++) begin
      @(posedge ref_clk);
      int_enable <= j[0];
      for (int i = 0; i < 8; i++) begin
        bus_op(i, i[1:0]);
        wr = kd[i] == CPB_MWR || kd[i] == CPB_IOWR;
        io = kd[i] == CPB_IORD || kd[i] == CPB_IOWR;
        check(ek, kd[i]);
        check((wr ? ed : resp_rdata) & mk[i], ex[i]);
        if (kd[i] != CPB_INTA && kd[i] != CPB_HALT) begin
          check(t1_as, io ? 4'h0 : ad[i][19:16]);
          check({t1_bhe, t1_bus[0]}, bn[i] ^ 2'h3);
          check(ea, {io ? 4'h0 : ad[i][19:16], ad[i][15:1], ~bn[i][0]});
          check(t1_bus[15:1], ad[i][15:1]);
          check(t2_as, {1'h0, j[0], i[1:0]});
        end
      end
    end
    @(posedge ref_clk);
    int_enable <= 1'h0;
    irq_req <= 1'h1;
    last_instr();
    check(n_irq, 20'h0);
    int_enable <= 1'h1;
    last_instr();
    check(n_irq, 20'h1);
    irq_req <= 1'h0;
    int_enable <= 1'h0;
    nmi_req <= 1'h1;
    last_instr();
    check({nmi_type, 4'(n_nmi)}, 20'h021);
    last_instr();
    check(n_nmi, 20'h1);
    @(posedge ref_clk);
    nmi_req <= 1'h0;
    wait_instr <= 1'h1;
    settle(6);
    check(wait_release, 1'h0);
    test_level_n <= 1'h0;
    settle(6);
    check(wait_release, 1'h1);
    wait_instr <= 1'h0;
    hold_req <= 1'h1;
    settle(6);
    check({hold_ack, req_ready, link.ad_dev_oe, link.addr_status_oe, link.read_n_oe,
           link.upper_byte_enable_n_oe, link.cycle_status_oe}, 20'h40);
    hold_req <= 1'h0;
    settle(6);
    check(hold_ack, 1'h0);
    // A reset in the middle of a read must abort it and float the pins.
    req_valid <= 1'h1;
    req_kind <= CPB_MRD;
    req_ben <= 2'h3;
    settle(4);
    rst <= 1'h1;
    req_valid <= 1'h0;
    settle(4);
    check({link.ad_dev_oe, link.addr_status_oe, link.cycle_status_oe, link.read_n},
          20'h1);
    rst <= 1'h0;
    settle(1);
    while (req_ready !== 1'h1) settle(1);
    bus_op(4, 2'h2);
    check(resp_rdata, 20'hC3A5);
    wrap_up();
  end
endmodule // cpb_tb_top
